// file: shared/clock_ctrl_regs.vh
// Register offsets, field positions, reset values and timing counts for the wake/clock control block
`ifndef CLOCK_CTRL_REGS_VH
`define CLOCK_CTRL_REGS_VH

// Printed offsets are not multiples of four: these are word indices
`define SECONDARY_TIMER_CONTROL_IDX 12'hFCD
`define OSCILLATOR_CONTROL_IDX 12'hFD3
// Byte address is four times the index
`define SECONDARY_TIMER_CONTROL_ADDR 14'h3F34
`define OSCILLATOR_CONTROL_ADDR 14'h3F4C
// Own register for primary oscillator mode configuration
`define WAKE_CONFIG_ADDR 14'h0000

// secondary_timer_control fields
`define STC_OSC_EN_BIT 3
`define STC_CLK_ACTIVE_BIT 6
`define STC_RESET 8'h00

// oscillator_control fields
`define OSC_IDLE_ON_SLEEP_BIT 7
`define OSC_FREQ_LSB 4
`define OSC_FREQ_MSB 6
`define OSC_START_DONE_BIT 3
`define OSC_INT_STABLE_BIT 2
`define OSC_SEL_LSB 0
`define OSC_SEL_MSB 1
// Internal oscillator frequency select: 1 MHz after reset
`define OSC_FREQ_1MHZ 3'h4
`define OSC_RESET 8'h40

// clock_select_field encodings
`define SEL_PRIMARY 2'h0
`define SEL_SECONDARY 2'h1
`define SEL_INTERNAL 2'h2

// Primary oscillator modes (wake_config bits 2:0)
`define PM_LOW_POWER_CRYSTAL 3'h0
`define PM_STANDARD_CRYSTAL 3'h1
`define PM_HIGH_SPEED_CRYSTAL 3'h2
`define PM_HIGH_SPEED_PLL 3'h3
`define PM_EXTERNAL_CLOCK 3'h4
`define PM_RESISTOR_CAPACITOR 3'h5
`define PM_INTERNAL_OSC_IO 3'h6
`define WAKE_CONFIG_RESET 8'h06

// Timing: times in ns, counts derived at 10 ns clock period
`define CLK_PERIOD_NS 10
`define CPU_PREP_DELAY_NS 10000
`define CPU_PREP_DELAY_CYC ((`CPU_PREP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_LOCK_TIME_NS 2000000
`define PLL_LOCK_TIME_CYC ((`PLL_LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_UP_TIMER_CYCLES 1024
`define INTERNAL_OSC_SETTLE_NS 1000000
`define INTERNAL_OSC_SETTLE_CYC ((`INTERNAL_OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: logic/delay_timer.v
// One-shot delay timer: loaded with a count, pulses done when it has run out
`timescale 1ns/10ps
`default_nettype none
module delay_timer (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire start,
  input wire abort,
  input wire [23:0] length,
  // Status
  output reg busy,
  output reg done
);
  reg [23:0] count;

  // Counts down once per cycle; done is a one-cycle pulse at expiry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 24'h000000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        count <= length;
        busy <= 1'b1;
      end else if (busy) begin
        if (count <= 24'h000001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 24'h000001;
        end
      end
    end
  end
endmodule // delay_timer
`default_nettype wire

// file: logic/wake_exit_and_secondary_clock.v
// Wake-up exit sequencing and secondary oscillator clock control with APB registers
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "clock_ctrl_regs.vh"
module wake_exit_and_secondary_clock #(
  parameter START_UP_CYCLES = `START_UP_TIMER_CYCLES,
  parameter PLL_LOCK_CYCLES = `PLL_LOCK_TIME_CYC,
  parameter SETTLE_CYCLES = `INTERNAL_OSC_SETTLE_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // CPU power events
  input wire sleep_cmd,
  input wire wake_event,
  // Oscillator monitor inputs (pins, synchronised here)
  input wire secondary_osc_fail,
  input wire clock_monitor_en,
  // Clock and CPU control outputs
  output reg cpu_run,
  output reg [1:0] clock_source,
  output reg primary_osc_on,
  output reg internal_osc_on,
  output reg secondary_osc_on,
  output reg in_secondary_idle
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_IDLE = 2'h2;
  localparam ST_WAKE = 2'h3;

  reg [1:0] state;
  reg [7:0] stc;
  reg [7:0] osc;
  reg [7:0] wake_config;
  reg primary_stopped;
  reg fail_meta;
  reg fail_sync;
  reg mon_meta;
  reg mon_sync;
  reg prep_start;
  reg osc_start;
  reg settle_start;
  reg [23:0] osc_len;
  wire prep_busy;
  wire prep_done;
  wire osc_busy;
  wire osc_done;
  wire settle_done;
  wire settle_busy;
  wire [2:0] pmode;
  wire crystal_mode;
  wire pll_mode;
  wire int_mode;
  wire apb_write;
  wire apb_read;
  wire secondary_supplies;
  wire primary_selected;

  assign pmode = wake_config[2:0];
  assign crystal_mode = (pmode == `PM_LOW_POWER_CRYSTAL) || (pmode == `PM_STANDARD_CRYSTAL) ||
                        (pmode == `PM_HIGH_SPEED_CRYSTAL);
  assign pll_mode = (pmode == `PM_HIGH_SPEED_PLL);
  assign int_mode = (osc[`OSC_SEL_MSB:`OSC_SEL_LSB] == `SEL_INTERNAL) || (pmode == `PM_INTERNAL_OSC_IO);
  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && !penable && !pwrite;
  assign primary_selected = (osc[`OSC_SEL_MSB:`OSC_SEL_LSB] == `SEL_PRIMARY);
  // Secondary supplies the clock only while selected, enabled and not failed under the monitor
  assign secondary_supplies = (osc[`OSC_SEL_MSB:`OSC_SEL_LSB] == `SEL_SECONDARY) && stc[`STC_OSC_EN_BIT] &&
                              !(mon_sync && fail_sync);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops each; only the second stage is read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_meta <= 1'b0;
      fail_sync <= 1'b0;
      mon_meta <= 1'b0;
      mon_sync <= 1'b0;
    end else begin
      fail_meta <= secondary_osc_fail;
      fail_sync <= fail_meta;
      mon_meta <= clock_monitor_en;
      mon_sync <= mon_meta;
    end
  end

  // ----------------------------------------------------------------
  // Delay timers
  // ----------------------------------------------------------------
  // Preparation count held as a parameter so it can be cut to the timer width on purpose
  localparam PREP_CYCLES = `CPU_PREP_DELAY_CYC;

  // CPU preparation delay, started at the wake event
  delay_timer prep_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(prep_start),
    .abort(1'b0),
    .length(PREP_CYCLES[23:0]),
    .busy(prep_busy),
    .done(prep_done)
  );

  // Start-up timer, plus PLL lock when in PLL mode, started together with prep
  delay_timer osc_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(osc_start),
    .abort(1'b0),
    .length(osc_len),
    .busy(osc_busy),
    .done(osc_done)
  );

  // Internal oscillator settle period; execution is not held for it
  delay_timer settle_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(settle_start),
    .abort(1'b0),
    .length(SETTLE_CYCLES[23:0]),
    .busy(settle_busy),
    .done(settle_done)
  );

  // Start-up length: PLL lock time is added after the start-up timer
  always @* begin
    if (pll_mode) begin
      osc_len = START_UP_CYCLES[23:0] + PLL_LOCK_CYCLES[23:0];
    end else begin
      osc_len = START_UP_CYCLES[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
      primary_stopped <= 1'b0;
      prep_start <= 1'b0;
      osc_start <= 1'b0;
      settle_start <= 1'b0;
      cpu_run <= 1'b1;
      in_secondary_idle <= 1'b0;
    end else begin
      prep_start <= 1'b0;
      osc_start <= 1'b0;
      settle_start <= 1'b0;
      case (state)
        ST_RUN: begin
          if (sleep_cmd) begin
            cpu_run <= 1'b0;
            // With the secondary selected, sleep always idles on it, whatever the idle bit holds
            if (osc[`OSC_IDLE_ON_SLEEP_BIT] || (osc[`OSC_SEL_MSB:`OSC_SEL_LSB] == `SEL_SECONDARY)) begin
              state <= ST_IDLE;
              // Primary keeps running only when it is the selected source
              primary_stopped <= !primary_selected;
              in_secondary_idle <= (osc[`OSC_SEL_MSB:`OSC_SEL_LSB] == `SEL_SECONDARY);
            end else begin
              state <= ST_SLEEP;
              primary_stopped <= 1'b1;
            end
          end
        end
        ST_SLEEP, ST_IDLE: begin
          if (wake_event) begin
            state <= ST_WAKE;
            in_secondary_idle <= 1'b0;
            prep_start <= 1'b1;
            // Start-up timer only when waking back onto a stopped crystal/PLL primary
            osc_start <= primary_stopped && primary_selected && (crystal_mode || pll_mode);
            settle_start <= int_mode && primary_stopped;
          end
        end
        ST_WAKE: begin
          // Both delays overlap; resume once neither is pending
          if (!prep_start && !prep_busy && !osc_start && !osc_busy) begin
            state <= ST_RUN;
            cpu_run <= 1'b1;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Software fields, hardware status flags; hardware set wins over stop-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stc <= `STC_RESET;
      osc <= `OSC_RESET;
      wake_config <= `WAKE_CONFIG_RESET;
    end else begin
      if (apb_write && paddr == `SECONDARY_TIMER_CONTROL_ADDR) begin
        stc[`STC_OSC_EN_BIT] <= pwdata[`STC_OSC_EN_BIT];
        stc[5:4] <= pwdata[5:4];
        stc[2:0] <= pwdata[2:0];
        stc[7] <= pwdata[7];
      end
      if (apb_write && paddr == `OSCILLATOR_CONTROL_ADDR) begin
        osc[`OSC_IDLE_ON_SLEEP_BIT] <= pwdata[`OSC_IDLE_ON_SLEEP_BIT];
        osc[`OSC_FREQ_MSB:`OSC_FREQ_LSB] <= pwdata[`OSC_FREQ_MSB:`OSC_FREQ_LSB];
        osc[`OSC_SEL_MSB:`OSC_SEL_LSB] <= pwdata[`OSC_SEL_MSB:`OSC_SEL_LSB];
      end
      if (apb_write && paddr == `WAKE_CONFIG_ADDR) begin
        wake_config[2:0] <= pwdata[2:0];
      end
      stc[`STC_CLK_ACTIVE_BIT] <= secondary_supplies;
      // Ready flags: cleared in sleep in their oscillator modes and when their timer starts, set after its delay
      if (osc_done) begin
        osc[`OSC_START_DONE_BIT] <= 1'b1;
      end else if (osc_start || (state == ST_SLEEP && (crystal_mode || pll_mode))) begin
        osc[`OSC_START_DONE_BIT] <= 1'b0;
      end
      if (settle_done) begin
        osc[`OSC_INT_STABLE_BIT] <= 1'b1;
      end else if (settle_start || (state == ST_SLEEP && int_mode)) begin
        osc[`OSC_INT_STABLE_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, data registered in setup phase
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_read) begin
        case (paddr)
          `SECONDARY_TIMER_CONTROL_ADDR: prdata <= {24'h000000, stc};
          `OSCILLATOR_CONTROL_ADDR: prdata <= {24'h000000, osc};
          `WAKE_CONFIG_ADDR: prdata <= {24'h000000, 5'h00, wake_config[2:0]};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  // Secondary stays on through every mode while enabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_osc_on <= 1'b0;
      primary_osc_on <= 1'b1;
      internal_osc_on <= 1'b1;
      clock_source <= `SEL_PRIMARY;
    end else begin
      secondary_osc_on <= stc[`STC_OSC_EN_BIT];
      primary_osc_on <= !(state == ST_SLEEP) && !(state == ST_IDLE && primary_stopped);
      internal_osc_on <= (state != ST_SLEEP);
      if (secondary_supplies) begin
        clock_source <= `SEL_SECONDARY;
      end else if (osc[`OSC_SEL_MSB:`OSC_SEL_LSB] == `SEL_SECONDARY) begin
        clock_source <= `SEL_INTERNAL;
      end else begin
        clock_source <= osc[`OSC_SEL_MSB:`OSC_SEL_LSB];
      end
    end
  end
endmodule // wake_exit_and_secondary_clock
`default_nettype wire

// file: testbench/wake_clock_properties.sv
// Port-level assertions for the wake exit and secondary clock block
`timescale 1ns/10ps
`default_nettype none
`include "clock_ctrl_regs.vh"
module wake_clock_properties #(
  parameter int START_UP_CYCLES = 1024,
  parameter int PLL_LOCK_CYCLES = 200000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Power events and monitor
  input wire logic sleep_cmd,
  input wire logic wake_event,
  input wire logic secondary_osc_fail,
  input wire logic clock_monitor_en,
  // Clock control outputs
  input wire logic cpu_run,
  input wire logic [1:0] clock_source,
  input wire logic secondary_osc_on,
  input wire logic in_secondary_idle
);
  // ----------------
  // Helper counter
  // ----------------
  // Delays overlap, so the longest one alone bounds the halt
  localparam int SLOW = START_UP_CYCLES + PLL_LOCK_CYCLES;
  localparam int MAXW = (SLOW > `CPU_PREP_DELAY_CYC ? SLOW : `CPU_PREP_DELAY_CYC) + 8;
  logic [23:0] wcnt;
  // Cycles halted since the wake; saturates so a lost wake stays visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt <= 24'h000000;
    else if (cpu_run) wcnt <= 24'h000000;
    else if (wake_event) wcnt <= 24'h000001;
    else if (wcnt != 24'h000000 && wcnt != 24'hFFFFFF) wcnt <= wcnt + 24'h000001;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bus_zero_wait: assert property (psel && !penable |=> pready) else $error("no zero-wait ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_bus_no_error: assert property (pready |-> !pslverr) else $error("slave error");
  a_enable_write: assert property (psel && penable && pwrite && pready &&
    paddr == `SECONDARY_TIMER_CONTROL_ADDR |=> ##1 secondary_osc_on == $past(pwdata[3], 2))
    else $error("enable not followed");
  a_osc_stays_on: assert property (secondary_osc_on && !cpu_run && !psel |=> secondary_osc_on)
    else $error("secondary stopped asleep");
  a_sleep_halts: assert property (cpu_run && sleep_cmd |=> !cpu_run) else $error("sleep ignored");
  a_run_holds: assert property (cpu_run && !sleep_cmd |=> cpu_run) else $error("run dropped");
  a_prep_floor: assert property ($rose(cpu_run) |-> wcnt >= 1000) else $error("woke early");
  a_wake_ceiling: assert property (!cpu_run |-> wcnt <= MAXW) else $error("woke late");
  a_idle_secondary: assert property (in_secondary_idle |-> !cpu_run && clock_source == `SEL_SECONDARY)
    else $error("bad secondary idle");
  a_fail_fallback: assert property (clock_monitor_en && secondary_osc_fail &&
    clock_source == `SEL_SECONDARY |-> ##[1:6] clock_source == `SEL_INTERNAL) else $error("no fallback");
  c_wake: cover property ($rose(cpu_run));
  c_secondary_idle_mode: cover property (in_secondary_idle);
  c_fallback: cover property (clock_source == `SEL_INTERNAL);
endmodule // wake_clock_properties
bind wake_exit_and_secondary_clock wake_clock_properties #(.START_UP_CYCLES(START_UP_CYCLES),
  .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sleep_cmd(sleep_cmd), .wake_event(wake_event),
  .secondary_osc_fail(secondary_osc_fail), .clock_monitor_en(clock_monitor_en), .cpu_run(cpu_run),
  .clock_source(clock_source), .secondary_osc_on(secondary_osc_on), .in_secondary_idle(in_secondary_idle));
`default_nettype wire

// file: testbench/testbench.sv
// Register and wake sequencing bench for the wake exit and secondary clock block
`timescale 1ns/10ps
`default_nettype none
`include "clock_ctrl_regs.vh"
module testbench;
  localparam int SU = 1500;
  localparam int PL = 600;
  localparam int PREP = `CPU_PREP_DELAY_CYC;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sleep_cmd, wake_event, secondary_osc_fail, clock_monitor_en;
  logic cpu_run, secondary_osc_on, in_secondary_idle, primary_osc_on, internal_osc_on;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] clock_source;
  int n_fail, n_checks, lo, mk;
  // Long counts shortened so each wake stays within about two thousand one hundred cycles
  wake_exit_and_secondary_clock #(.START_UP_CYCLES(SU), .PLL_LOCK_CYCLES(PL), .SETTLE_CYCLES(1500))
    wake_exit_and_secondary_clock_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_cmd(sleep_cmd), .wake_event(wake_event), .secondary_osc_fail(secondary_osc_fail),
    .clock_monitor_en(clock_monitor_en), .cpu_run(cpu_run), .clock_source(clock_source),
    .primary_osc_on(primary_osc_on), .internal_osc_on(internal_osc_on), .secondary_osc_on(secondary_osc_on),
    .in_secondary_idle(in_secondary_idle));
  // ----------------
  // Tasks
  // ----------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for ready under a bound
  task apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    if (i >= 50) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdm(input logic [13:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q & m, e);
  endtask
  // Sleep, check state asleep, wake, then time the restart
  task nap(input int lo, input logic sidl, input logic [1:0] on, input logic [31:0] m, input logic [31:0] e);
    int n;
    @(posedge pclk);
    sleep_cmd <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    repeat (20) @(posedge pclk);
    check({30'h0, cpu_run, in_secondary_idle}, {30'h0, 1'b0, sidl});
    check({31'h0, secondary_osc_on}, {31'h0, sidl});
    check({30'h0, primary_osc_on, internal_osc_on}, {30'h0, on});
    rdm(`OSCILLATOR_CONTROL_ADDR, m, e);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    n = 0;
    while (cpu_run !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n >= lo && n <= lo + 8), 32'h1);
  endtask
  task conclude;
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------
  // Stimulus
  // ----------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard: a clean run needs about sixteen thousand cycles, so sixty thousand means a hang
  initial begin
    #600000;
    n_fail++;
    conclude;
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_cmd, wake_event, secondary_osc_fail, clock_monitor_en} = 8'h00;
    paddr = 14'h0000;
    pwdata = 32'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdm(`SECONDARY_TIMER_CONTROL_ADDR, 32'hFFFFFFFF, 32'h00);
    rdm(`OSCILLATOR_CONTROL_ADDR, 32'hFFFFFFFF, 32'h40);
    rdm(`WAKE_CONFIG_ADDR, 32'hFFFFFFFF, 32'h06);
    rdm(14'h3F30, 32'hFFFFFFFF, 32'h0);
    // Every primary mode from sleep; ends in crystal mode for the idle case
    for (int m = 6; m >= 0; m--) begin
      apb(1'b1, `WAKE_CONFIG_ADDR, m);
      lo = m <= 2 ? SU : (m == 3 ? SU + PL : PREP);
      mk = m <= 3 ? 32'h08 : (m == 6 ? 32'h04 : 32'h0);
      nap(lo, 1'b0, 2'b00, mk, 32'h0);
      rdm(`OSCILLATOR_CONTROL_ADDR, mk, m == 6 ? 32'h0 : mk);
      repeat (600) @(posedge pclk);
      rdm(`OSCILLATOR_CONTROL_ADDR, mk, mk);
    end
    apb(1'b1, `OSCILLATOR_CONTROL_ADDR, 32'hC0);
    nap(PREP, 1'b0, 2'b11, 32'h08, 32'h08);
    apb(1'b1, `SECONDARY_TIMER_CONTROL_ADDR, 32'h08);
    repeat (100) @(posedge pclk);
    check({31'h0, secondary_osc_on}, 32'h1);
    // Idle bit left clear: sleep on the secondary must still idle on it
    apb(1'b1, `OSCILLATOR_CONTROL_ADDR, 32'h41);
    rdm(`SECONDARY_TIMER_CONTROL_ADDR, 32'hFF, 32'h48);
    check({30'h0, clock_source}, 32'h1);
    nap(PREP, 1'b1, 2'b01, 32'h0, 32'h0);
    clock_monitor_en <= 1'b1;
    secondary_osc_fail <= 1'b1;
    repeat (10) @(posedge pclk);
    check({30'h0, clock_source}, 32'h2);
    rdm(`SECONDARY_TIMER_CONTROL_ADDR, 32'hFF, 32'h08);
    apb(1'b1, `SECONDARY_TIMER_CONTROL_ADDR, 32'h00);
    repeat (2) @(posedge pclk);
    check({31'h0, secondary_osc_on}, 32'h0);
    // Second reset in mid-run restores defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    secondary_osc_fail <= 1'b0;
    rdm(`OSCILLATOR_CONTROL_ADDR, 32'hFFFFFFFF, 32'h40);
    check({30'h0, clock_source}, 32'h0);
    conclude;
  end
endmodule // testbench
`default_nettype wire
